// >>> hdl/idu_regs.svh
/*
  Register offsets, field positions, reset values and sequence counts of the
  iterative divide unit.
  Assumes inclusion by bare name from idu_top, the only file of the unit that includes it.
*/
`ifndef IDU_REGS_SVH
`define IDU_REGS_SVH

// APB byte offsets
`define IDU_OFS_QUOT      8'h00
`define IDU_OFS_REM       8'h04
`define IDU_OFS_STAT      8'h08
`define IDU_OFS_CTRL      8'h0c

// Control register
`define IDU_CTRL_EN_BIT   0
`define IDU_CTRL_RST      32'h0000_0001

// Status register fields
`define IDU_STAT_C_BIT    0
`define IDU_STAT_Z_BIT    1
`define IDU_STAT_OV_BIT   2
`define IDU_STAT_N_BIT    3
`define IDU_STAT_BUSY_BIT 4
`define IDU_STAT_STEP_LSB 8

// Working register reset values
`define IDU_W0_RST        16'h0000
`define IDU_W1_RST        16'h0000

// Instruction decode
`define IDU_OP_UNS        9'h1b1
`define IDU_OP_FRAC       9'h1b2

// Sequence counts: one load issue, sixteen quotient steps, one finishing issue
`define IDU_ISSUES        5'h12
`define IDU_ITER_LAST     5'h10

`endif

// >>> hdl/idu_pkg.sv
/*
  Types of the iterative divide unit: divide mode, sequence phase and the
  packed state record of the top module.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package idu_pkg;

  typedef enum logic [1:0] {
    IDU_PH_IDLE  = 2'b00,
    IDU_PH_ITER  = 2'b01,
    IDU_PH_FINAL = 2'b10
  } idu_phase_t;

  typedef enum logic [0:0] {
    IDU_MODE_UNS  = 1'b0,
    IDU_MODE_FRAC = 1'b1
  } idu_mode_t;

  typedef struct packed {
    logic [15:0] w0;
    logic [15:0] w1;
    logic [15:0] dvsr;
    idu_mode_t   mode;
    idu_phase_t  phase;
    logic [4:0]  step;
    logic        neg_q;
    logic        neg_r;
    logic        ovf_pend;
    logic        flag_n;
    logic        flag_ov;
    logic        flag_z;
    logic        flag_c;
    logic        trap;
    logic        enable;
    logic [31:0] prdata;
  } idu_state_t;

endpackage : idu_pkg

// >>> hdl/idu_step.sv
/*
  One restoring divide step on a 32-bit partial remainder/quotient pair.
  Assumes the high word is already below the divisor, so a step never overflows.
*/
module idu_step (
  input  wire logic [15:0] rem_hi,
  input  wire logic [15:0] rem_lo,
  input  wire logic [15:0] dvsr,
  output logic      [15:0] nxt_hi,
  output logic      [15:0] nxt_lo,
  output logic             carry
);

  logic [16:0] part;
  logic [16:0] diff;

  always_comb begin
    part   = {rem_hi, rem_lo[15]};
    diff   = part - {1'b0, dvsr};
    carry  = (part >= {1'b0, dvsr});
    nxt_hi = carry ? diff[15:0] : part[15:0];
    nxt_lo = {rem_lo[14:0], carry};
  end

endmodule : idu_step

// >>> hdl/idu_top.sv
/*
  Iterative divide unit: unsigned 16/16 and 32/16 divide and signed fractional
  16/16 divide, one step per issued divide instruction, with an APB window on
  the working registers, flags and control.
  Assumes the instruction decoder and repeat logic issue the divide on pclk
  and supply the selected operand values in the same cycle.
*/
// Chosen here: the register offsets and the APB register port.
// Functional notes
// - Single-width unsigned: dividend to quotient register, remainder register cleared.
// - Double-width unsigned: register pair loads high and low working words.
// - Finished: quotient in working register 0, remainder in register 1.
// - Unsigned divides always clear the negative flag.
// - Overflow flag set on overflow, cleared otherwise.
// - Zero flag set when final remainder is zero.
// - Carry flag is algorithm scratch; final value undefined.
// - Unsigned divide decoded from its opcode pattern, fields t, v, W, s.
// - Double-width quotient beyond 16 bits sets overflow; results invalid.
// - Zero divisor raises arithmetic trap in the first cycle.
// - Sequence pauses at any issue boundary and resumes correctly.
// - One word each; 18 issue cycles plus one for the repeat.
// - Fractional divide: quotient register cleared, dividend to remainder register.
// - Fractional remainder takes the sign of the dividend.
// - Fractional: negative flag follows the final remainder sign.
// - Fractional dividend magnitude above divisor sets overflow; results invalid.
// - Fractional divide decoded from its opcode pattern, fields t and s.
`include "idu_regs.svh"

module idu_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        exec_valid,
  input  wire logic [23:0] exec_instr,
  output logic      [3:0]  dividend_lo_sel,
  output logic      [3:0]  dividend_hi_sel,
  output logic      [3:0]  divisor_sel,
  input  wire logic [15:0] dividend_lo,
  input  wire logic [15:0] dividend_hi,
  input  wire logic [15:0] divisor,
  output logic      [15:0] quotient_register,
  output logic      [15:0] remainder_register,
  output logic      [3:0]  status_flags_register,
  output logic             divide_busy,
  output logic             arith_trap
);

  idu_pkg::idu_state_t state_ff;
  idu_pkg::idu_state_t nxt_state;

  logic        is_uns;
  logic        is_frac;
  logic        is_div;
  logic        dbl;
  logic [15:0] abs_a;
  logic [15:0] abs_b;
  logic [15:0] fin_q;
  logic [15:0] fin_r;
  logic [15:0] step_hi;
  logic [15:0] step_lo;
  logic        step_c;
  logic        apb_wr;
  logic        apb_hit;
  logic [15:0] abs_w1;
  logic        frac_first;
  logic [15:0] step_in_hi;
  logic [15:0] step_in_lo;

  function automatic logic [15:0] neg16(input logic [15:0] v);
    neg16 = (~v) + 16'h0001;
  endfunction : neg16

  function automatic logic [15:0] abs16(input logic [15:0] v);
    abs16 = v[15] ? neg16(v) : v;
  endfunction : abs16

  function automatic logic [15:0] apply_sign(input logic neg, input logic [15:0] v);
    apply_sign = neg ? neg16(v) : v;
  endfunction : apply_sign

  function automatic logic op_uns(input logic [23:0] ins);
    op_uns = (ins[23:15] == `IDU_OP_UNS) && (ins[5:4] == 2'b00);
  endfunction : op_uns

  function automatic logic op_frac(input logic [23:0] ins);
    op_frac = (ins[23:15] == `IDU_OP_FRAC) && (ins[10:4] == 7'h00);
  endfunction : op_frac

  function automatic logic busy_of(input idu_pkg::idu_phase_t ph);
    busy_of = (ph != idu_pkg::IDU_PH_IDLE);
  endfunction : busy_of

  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == `IDU_OFS_QUOT) || (a == `IDU_OFS_REM) ||
               (a == `IDU_OFS_STAT) || (a == `IDU_OFS_CTRL);
  endfunction : addr_hit

  function automatic logic [31:0] read_mux(input idu_pkg::idu_state_t st,
                                           input logic [7:0] a);
    logic [31:0] stat;
    stat = 32'h0000_0000;
    stat[`IDU_STAT_C_BIT]  = st.flag_c;
    stat[`IDU_STAT_Z_BIT]  = st.flag_z;
    stat[`IDU_STAT_OV_BIT] = st.flag_ov;
    stat[`IDU_STAT_N_BIT]  = st.flag_n;
    stat[`IDU_STAT_BUSY_BIT] = busy_of(st.phase);
    stat[`IDU_STAT_STEP_LSB +: 5] = st.step;
    unique case (a)
      `IDU_OFS_QUOT: read_mux = {16'h0000, st.w0};
      `IDU_OFS_REM:  read_mux = {16'h0000, st.w1};
      `IDU_OFS_STAT: read_mux = stat;
      `IDU_OFS_CTRL: read_mux = {31'h0000_0000, st.enable};
      default:       read_mux = 32'h0000_0000;
    endcase
  endfunction : read_mux

  // Operand field extraction for the register file read ports
  assign dividend_hi_sel = exec_instr[14:11];
  assign dividend_lo_sel = op_frac(exec_instr) ? exec_instr[14:11] : exec_instr[10:7];
  assign divisor_sel     = exec_instr[3:0];

  // Opcode match; fields that must be zero are checked too
  assign is_uns  = exec_valid && op_uns(exec_instr);
  assign is_frac = exec_valid && op_frac(exec_instr);
  assign is_div  = (is_uns || is_frac) && state_ff.enable;
  assign dbl     = exec_instr[6];

  // Magnitudes feed the fractional load only; the unsigned path never reads them
  assign abs_a = abs16(dividend_lo);
  assign abs_b = abs16(divisor);

  // Sign restore at the end; magnitudes are used throughout the steps
  assign fin_q = apply_sign(state_ff.neg_q, state_ff.w0);
  assign fin_r = apply_sign(state_ff.neg_r, state_ff.w1);

  // Fractional load keeps the raw dividend; the first step reads its magnitude
  // already scaled by 2^15, so sixteen steps still fit the repeat count
  assign frac_first = (state_ff.mode == idu_pkg::IDU_MODE_FRAC) &&
                      (state_ff.phase == idu_pkg::IDU_PH_ITER) &&
                      (state_ff.step == 5'h01);
  assign abs_w1     = abs16(state_ff.w1);
  assign step_in_hi = frac_first ? {1'b0, abs_w1[15:1]} : state_ff.w1;
  assign step_in_lo = frac_first ? {abs_w1[0], 15'h0000} : state_ff.w0;

  idu_step u_step (
    .rem_hi (step_in_hi),
    .rem_lo (step_in_lo),
    .dvsr   (state_ff.dvsr),
    .nxt_hi (step_hi),
    .nxt_lo (step_lo),
    .carry  (step_c)
  );

  // Zero wait states: every transfer completes in its first access cycle
  assign apb_wr  = psel && penable && pwrite;
  assign apb_hit = addr_hit(paddr);

  always_comb begin
    nxt_state      = state_ff;
    nxt_state.trap = 1'b0;

    unique case (state_ff.phase)
      idu_pkg::IDU_PH_IDLE: begin
        if (is_div) begin
          if (divisor == 16'h0000) begin
            // No step is taken; the trap handler owns the abandoned repeat
            nxt_state.trap = 1'b1;
          end else if (is_uns) begin
            nxt_state.mode  = idu_pkg::IDU_MODE_UNS;
            nxt_state.dvsr  = divisor;
            nxt_state.neg_q = 1'b0;
            nxt_state.neg_r = 1'b0;
            nxt_state.w0    = dividend_lo;
            if (dbl) begin
              // Low word from the even register, high word from the next
              nxt_state.w1       = dividend_hi;
              nxt_state.ovf_pend = (dividend_hi >= divisor);
            end else begin
              // Only the double form can overflow
              nxt_state.w1       = 16'h0000;
              nxt_state.ovf_pend = 1'b0;
            end
            nxt_state.phase = idu_pkg::IDU_PH_ITER;
            nxt_state.step  = 5'h01;
          end else begin
            // Raw dividend held; signs and divisor magnitude latched for the steps
            nxt_state.mode     = idu_pkg::IDU_MODE_FRAC;
            nxt_state.dvsr     = abs_b;
            nxt_state.neg_q    = dividend_lo[15] ^ divisor[15];
            nxt_state.neg_r    = dividend_lo[15];
            nxt_state.w1       = dividend_lo;
            nxt_state.w0       = 16'h0000;
            nxt_state.ovf_pend = (abs_a > abs_b);
            nxt_state.phase    = idu_pkg::IDU_PH_ITER;
            nxt_state.step     = 5'h01;
          end
        end
      end

      idu_pkg::IDU_PH_ITER: begin
        // A gap in issue (interrupt) simply holds everything
        if (is_div) begin
          nxt_state.w1     = step_hi;
          nxt_state.w0     = step_lo;
          nxt_state.flag_c = step_c;
          nxt_state.step   = state_ff.step + 5'h01;
          // Steps run on issues 2 to 17; the eighteenth takes no step, it restores signs and sets the flags
          if (state_ff.step == `IDU_ITER_LAST) begin
            nxt_state.phase = idu_pkg::IDU_PH_FINAL;
          end
        end
      end

      idu_pkg::IDU_PH_FINAL: begin
        // Eighteenth issue: results and flags become valid here
        if (is_div) begin
          nxt_state.w0      = fin_q;
          nxt_state.w1      = fin_r;
          // Flags other than carry are written only here, so they stand until the next divide ends; carry changes on every step
          nxt_state.flag_ov = state_ff.ovf_pend;
          nxt_state.flag_z  = (fin_r == 16'h0000);
          if (state_ff.mode == idu_pkg::IDU_MODE_FRAC) begin
            nxt_state.flag_n = fin_r[15];
          end else begin
            nxt_state.flag_n = 1'b0;
          end
          nxt_state.phase = idu_pkg::IDU_PH_IDLE;
          nxt_state.step  = 5'h00;
        end
      end

      default: begin
        nxt_state.phase = idu_pkg::IDU_PH_IDLE;
        nxt_state.step  = 5'h00;
      end
    endcase

    // Software access wins over a step in the same cycle, so a context restore
    // after an interrupt is never overwritten
    if (apb_wr) begin
      unique case (paddr)
        `IDU_OFS_QUOT: nxt_state.w0 = pwdata[15:0];
        `IDU_OFS_REM:  nxt_state.w1 = pwdata[15:0];
        `IDU_OFS_CTRL: nxt_state.enable = pwdata[`IDU_CTRL_EN_BIT];
        default: begin
        end
      endcase
    end

    // Read data is captured in the setup cycle and stands through the access
    if (psel && !penable) begin
      if (pwrite) begin
        nxt_state.prdata = 32'h0000_0000;
      end else begin
        nxt_state.prdata = read_mux(state_ff, paddr);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Every field named, so no bit of the record rests on a default
      state_ff.w0       <= `IDU_W0_RST;
      state_ff.w1       <= `IDU_W1_RST;
      state_ff.dvsr     <= 16'h0000;
      state_ff.mode     <= idu_pkg::IDU_MODE_UNS;
      state_ff.phase    <= idu_pkg::IDU_PH_IDLE;
      state_ff.step     <= 5'h00;
      state_ff.neg_q    <= 1'b0;
      state_ff.neg_r    <= 1'b0;
      state_ff.ovf_pend <= 1'b0;
      state_ff.flag_n   <= 1'b0;
      state_ff.flag_ov  <= 1'b0;
      state_ff.flag_z   <= 1'b0;
      state_ff.flag_c   <= 1'b0;
      state_ff.trap     <= 1'b0;
      state_ff.enable   <= ((`IDU_CTRL_RST & 32'h0000_0001) != 32'h0000_0000);
      state_ff.prdata   <= 32'h0000_0000;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Data outputs come straight from the state record, no logic after the flops
  assign prdata                = state_ff.prdata;
  assign pready                = 1'b1;
  assign pslverr               = psel && penable && !apb_hit;
  assign quotient_register     = state_ff.w0;
  assign remainder_register    = state_ff.w1;
  assign status_flags_register = {state_ff.flag_n,
                                  state_ff.flag_ov,
                                  state_ff.flag_z,
                                  state_ff.flag_c};
  assign divide_busy           = busy_of(state_ff.phase);
  assign arith_trap            = state_ff.trap;

endmodule : idu_top

// >>> tb/idu_top_properties.sv
/*
  Concurrent checks on the ports of the iterative divide unit.
  Assumes a bind onto idu_top; one clock domain, pclk, reset presetn.
*/
module idu_top_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        exec_valid,
  input wire logic [23:0] exec_instr,
  input wire logic [15:0] divisor,
  input wire logic [15:0] quotient_register,
  input wire logic [15:0] remainder_register,
  input wire logic [3:0]  status_flags_register,
  input wire logic        divide_busy,
  input wire logic        arith_trap
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready; pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_err; psel && penable && |{paddr[7:4], paddr[1:0]} |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("unmapped access without error");
  property p_noerr; !penable |-> !pslverr; endproperty
  a_noerr: assert property (p_noerr) else $error("error outside access phase");
  property p_trap; arith_trap |-> $past(exec_valid) && $past(divisor) == 16'h0; endproperty
  a_trap: assert property (p_trap) else $error("trap without zero divisor");
  property p_end; $fell(divide_busy) |-> $past(exec_valid); endproperty
  a_end: assert property (p_end) else $error("busy fell without an issue");
  property p_neg_uns; $fell(divide_busy) && !$past(exec_instr[16]) |-> !status_flags_register[3];
  endproperty
  a_neg_uns: assert property (p_neg_uns) else $error("negative set by unsigned");
  property p_zero;
    $fell(divide_busy) && !status_flags_register[2]
      |-> status_flags_register[1] == (remainder_register == 16'h0);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
  property p_neg_frac;
    $fell(divide_busy) && $past(exec_instr[16]) && !status_flags_register[2]
      |-> status_flags_register[3] == remainder_register[15];
  endproperty
  a_neg_frac: assert property (p_neg_frac) else $error("fractional sign flag wrong");
  property p_ov_single;
    $fell(divide_busy) && !$past(exec_instr[16]) && !$past(exec_instr[6])
      |-> !status_flags_register[2];
  endproperty
  a_ov_single: assert property (p_ov_single) else $error("single divide overflowed");
  // Partial state must survive an interrupt gap untouched
  property p_hold;
    divide_busy && !exec_valid && !(psel && penable && pwrite)
      |=> $stable(quotient_register) && $stable(remainder_register);
  endproperty
  a_hold: assert property (p_hold) else $error("state moved in a gap");
  c_trap: cover property (arith_trap);
  c_fin: cover property ($fell(divide_busy));
  c_err: cover property (pslverr);
endmodule : idu_top_properties

// >>> tb/idu_issuer.sv
/*
  Model of the instruction decoder and repeat control feeding the divider.
  Assumes the bench fills rf and calls issue; operands follow the selects.
*/
module idu_issuer (
  input  wire logic        pclk,
  input  wire logic [3:0]  dividend_lo_sel,
  input  wire logic [3:0]  dividend_hi_sel,
  input  wire logic [3:0]  divisor_sel,
  output logic             exec_valid,
  output logic      [23:0] exec_instr,
  output logic      [15:0] dividend_lo,
  output logic      [15:0] dividend_hi,
  output logic      [15:0] divisor
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] rf [16];
  initial begin
    exec_valid = 1'b0;
    exec_instr = 24'h0;
    foreach (rf[i]) rf[i] = 16'h0;
  end
  assign dividend_lo = rf[dividend_lo_sel];
  assign dividend_hi = rf[dividend_hi_sel];
  assign divisor     = rf[divisor_sel];
  // A gap cycle stands for an interrupt taken between repeat passes
  task automatic issue(input logic [23:0] ins, input int n, input logic gap);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      exec_instr <= ins;
      exec_valid <= 1'b1;
      if (gap) begin
        @(posedge pclk);
        exec_valid <= 1'b0;
      end
    end
    @(posedge pclk);
    exec_valid <= 1'b0;
  endtask : issue
endmodule : idu_issuer

// >>> tb/idu_top_tb.sv
/*
  Self-checking bench of the divide unit: APB window, all divide modes, trap.
  Assumes idu_top, the issuer model and the property checker are compiled.
*/
module idu_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, exec_valid, divide_busy, arith_trap, er;
  logic [23:0] exec_instr;
  logic [3:0] lo_sel, hi_sel, dv_sel, flags;
  logic [15:0] dividend_lo, dividend_hi, divisor, quo, rem;
  int n_fail = 0, n_compared = 0;
  always #10 pclk = ~pclk;
  idu_top dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .exec_valid(exec_valid), .exec_instr(exec_instr),
    .dividend_lo_sel(lo_sel), .dividend_hi_sel(hi_sel), .divisor_sel(dv_sel),
    .dividend_lo(dividend_lo), .dividend_hi(dividend_hi), .divisor(divisor),
    .quotient_register(quo), .remainder_register(rem), .status_flags_register(flags),
    .divide_busy(divide_busy), .arith_trap(arith_trap));
  idu_issuer part_u (.pclk(pclk), .dividend_lo_sel(lo_sel), .dividend_hi_sel(hi_sel),
    .divisor_sel(dv_sel), .exec_valid(exec_valid), .exec_instr(exec_instr),
    .dividend_lo(dividend_lo), .dividend_hi(dividend_hi), .divisor(divisor));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) n_fail++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Load step is checked after one issue, then the rest run with gaps
  task automatic do_div(input logic [23:0] ins, input logic [15:0] lo, hi, dv, q, r,
                        input logic [2:0] nvz);
    logic frac;
    frac = ins[16];
    @(posedge pclk);
    if (!frac) begin
      part_u.rf[ins[14:11]] <= hi;
    end
    part_u.rf[frac ? ins[14:11] : ins[10:7]] <= lo;
    part_u.rf[ins[3:0]] <= dv;
    part_u.issue(ins, 1, 1'b0);
    #1 chk("load q", frac ? 32'h0 : {16'h0, lo}, {16'h0, quo});
    chk("load r", {16'h0, frac ? lo : hi}, {16'h0, rem});
    part_u.issue(ins, 17, 1'b1);
    #1 chk("busy", 32'h0, {31'h0, divide_busy});
    if (nvz[1]) chk("ov", 32'h1, {31'h0, flags[2]});
    else begin
      chk("quot", {16'h0, q}, {16'h0, quo});
      chk("rem", {16'h0, r}, {16'h0, rem});
      chk("flags", {29'h0, nvz}, {29'h0, flags[3:1]});
    end
  endtask : do_div
  task automatic t_reset;
    chk("reset out", 32'h0, {26'h0, divide_busy, arith_trap, flags});
    chk("reset regs", 32'h0, {rem, quo});
    apb(1'b0, 8'h08, 32'h0);
    chk("status", 32'h0, rd);
    apb(1'b0, 8'h0c, 32'h0);
    chk("ctrl", 32'h1, rd);
  endtask : t_reset
  task automatic t_apb;
    apb(1'b1, 8'h00, 32'h1234);
    #1 chk("q port", 32'h1234, {16'h0, quo});
    apb(1'b1, 8'h08, 32'hff);
    apb(1'b0, 8'h08, 32'h0);
    chk("status ro", 32'h0, rd);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h1, {31'h0, er});
    apb(1'b1, 8'h0c, 32'h0);
    part_u.rf[4] <= 16'h0005;
    part_u.issue({9'h1b1, 4'h0, 4'h2, 1'b0, 2'b00, 4'h4}, 1, 1'b0);
    #1 chk("disabled", 32'h1234, {15'h0, divide_busy, quo});
    apb(1'b1, 8'h0c, 32'h1);
  endtask : t_apb
  // High-word field zero for single width, even low register for double
  task automatic t_uns;
    do_div({9'h1b1, 4'h0, 4'h2, 1'b0, 2'b00, 4'h4}, 16'h8000, 16'h0, 16'h0200,
           16'h0040, 16'h0, 3'b001);
    apb(1'b0, 8'h08, 32'h0);
    chk("stat word", 32'h0000_0002, rd & 32'hffff_fffe);
    do_div({9'h1b1, 4'hb, 4'ha, 1'b1, 2'b00, 4'hc}, 16'h2500, 16'h0042, 16'h2200,
           16'h01f2, 16'h0100, 3'b000);
    do_div({9'h1b1, 4'hb, 4'ha, 1'b1, 2'b00, 4'hc}, 16'h0, 16'h2200, 16'h2200,
           16'h0, 16'h0, 3'b010);
  endtask : t_uns
  task automatic t_frac;
    logic [15:0] tb [4][4] = '{'{16'h1000, 16'h4000, 16'h2000, 16'h0},
      '{16'h1000, 16'h8000, 16'hf000, 16'h0}, '{16'h8002, 16'h8001, 16'h7ffe, 16'h8002},
      '{16'h5000, 16'h4000, 16'h0, 16'h0}};
    logic [2:0] fl [4] = '{3'b001, 3'b001, 3'b100, 3'b010};
    for (int i = 0; i < 4; i++)
      do_div({9'h1b2, 4'h8, 7'h0, 4'h9}, tb[i][0], 16'h0, tb[i][1], tb[i][2], tb[i][3],
             fl[i]);
  endtask : t_frac
  task automatic t_trap;
    @(posedge pclk);
    part_u.rf[4] <= 16'h0;
    part_u.issue({9'h1b1, 4'h0, 4'h2, 1'b0, 2'b00, 4'h4}, 1, 1'b0);
    #1 chk("trap", 32'h1, {31'h0, arith_trap});
    @(posedge pclk);
    #1 chk("trap end", 32'h0, {30'h0, arith_trap, divide_busy});
  endtask : t_trap
  task automatic conclude;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1 t_reset();
    t_apb();
    t_uns();
    t_frac();
    t_trap();
    conclude();
  end
  // Whole run is a few hundred cycles; this bound only cuts a hang
  initial begin
    #400000;
    n_fail++;
    conclude();
  end
endmodule : idu_top_tb
bind idu_top idu_top_properties chk_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
  .exec_valid(exec_valid), .exec_instr(exec_instr), .divisor(divisor),
  .quotient_register(quotient_register), .remainder_register(remainder_register),
  .status_flags_register(status_flags_register), .divide_busy(divide_busy),
  .arith_trap(arith_trap));
